// File: arith_pkg.sv
// Shared constants for the arithmetic-unit datapath: widths, field positions,
// residue slot indices and the command set.
// Assumes a single 100 MHz clock domain shared with the control sequencer.
package arith_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DW = 64;
  localparam int EW = 4;
  localparam int XW = DW + EW;
  localparam int BW = 16;
  localparam int GW = 12;
  localparam int PW = 6;
  localparam int RW = 2;
  localparam int RN = 11;
  localparam int FIFO_DEPTH = 8;
  // ---------------------------------------------------------------
  // Operand field positions on the storage word
  // ---------------------------------------------------------------
  localparam int SHF_LSB = 0;
  localparam int MSK_BIT_LSB = 0;
  localparam int MSK_SEL_LSB = 16;
  localparam int MSK_ALW_LSB = 20;
  localparam int MSK_EXP_LSB = 24;
  localparam int FLT_SH_LSB = 0;
  localparam int FLT_MK_LSB = 5;
  // ---------------------------------------------------------------
  // Residue slots on residue_o
  // ---------------------------------------------------------------
  localparam int RI_SHIFT = 0;
  localparam int RI_MASK = 1;
  localparam int RI_FSH = 2;
  localparam int RI_FMK = 3;
  localparam int RI_A = 4;
  localparam int RI_CD = 5;
  localparam int RI_E = 6;
  localparam int RI_F = 7;
  localparam int RI_P = 8;
  localparam int RI_G = 9;
  localparam int RI_H = 10;
  // Decimal digit limits
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] DEC_ADJ = 4'h6;
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_SHIFT = 5'h01, OP_MASK = 5'h02, OP_FSAVE = 5'h03,
    OP_EXTRACT = 5'h04, OP_INSERT = 5'h05, OP_NORM = 5'h06, OP_SHR = 5'h07,
    OP_ADD = 5'h08, OP_LD_C = 5'h09, OP_LD_D = 5'h0a, OP_LD_E = 5'h0b,
    OP_LD_Q = 5'h0c, OP_MUL = 5'h0d, OP_DIV = 5'h0e, OP_G_EXT = 5'h0f,
    OP_H_EXT = 5'h10, OP_EXP_ADD = 5'h11, OP_G_INS = 5'h12,
    OP_STORE_A = 5'h13, OP_STORE_P = 5'h14, OP_FPUT = 5'h15, OP_LD_A = 5'h16
  } op_e;
endpackage

// File: arith_datapath.sv
// Barrel, adder and exponent datapath of the arithmetic unit, with the
// outbound word FIFO toward operand storage.
// Assumes the control sequencer issues one command per cycle on core_clk_i
// and presents the storage buffer word on st_data_i in the same cycle.
//
// How it works
// - Main barrel is a 64-bit rotator between adder and storage.
// - Extract rotates then masks output; insert masks input then rotates.
// - Main barrel normalizes mantissas and shifts right with zero fill.
// - 16-bit exponent barrel moves exponents, masked by the exponent mask amount.
// - Six-bit shift register sets rotation of both barrels.
// - 16-bit pattern register holds the partial mask for one portion.
// - Four-bit placement register picks portions receiving the pattern.
// - Four-bit enable register picks portions receiving all ones.
// - Five-bit and six-bit registers save float result shift and mask.
// - Residues kept for shift, main mask and both float save registers.
// - Three-input binary adder with decimal mode, 64 bits plus extension.
// - Leading-zero count encodes zeros ahead of accumulator data.
// - Six-bit binary and one-digit decimal multiply decoders pick multiples.
// - Divide estimates next quotient pair while current pair is corrected.
// - Accumulator is adder input and target; the multiple register can also take the sum.
// - Second operand feeds adder; holds small multiples during multiply.
// - Third operand holds decimal correction or large binary multiples.
// - 64-bit operand register holds multiplicand or divisor.
// - Multiple register holds 3x or 2x operand, or buffers adder output.
// - Six-bit transfer register passes product or quotient bits out.
// - Remainder copy mirrors accumulator bits 65 to 60 into divide decoder.
// - Twelve-bit exponent registers with adder; both inputs keep residues.
// - Residues for accumulator, second plus third, operand, multiple, transfer.
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Outbound word FIFO
// ---------------------------------------------------------------
module arith_fifo
  #(parameter int W = 64,
    parameter int D = 8)
  (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
  );
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s state_reg;
  fifo_s state_next;
  logic push;
  logic pop;

  // Flags straight from the occupancy count
  assign in_ready_o = state_reg.cnt != (AW+1)'(D);
  assign out_valid_o = state_reg.cnt != '0;
  assign out_data_o = state_reg.mem[state_reg.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wp] = in_data_i;
      state_next.wp = (state_reg.wp == AW'(D - 1)) ? '0 : state_reg.wp + 1'b1;
    end
    if (pop)
    begin
      state_next.rp = (state_reg.rp == AW'(D - 1)) ? '0 : state_reg.rp + 1'b1;
    end
    if (push && !pop)
    begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule

// ---------------------------------------------------------------
// Datapath top
// ---------------------------------------------------------------
module arith_datapath
  import arith_pkg::*;
  #(parameter int DEPTH = FIFO_DEPTH)
  (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Command from the control sequencer
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_op_i,
  input wire logic cmd_dec_i,
  input wire logic cmd_fbuf_i,
  output logic cmd_ready_o,
  // Storage buffer word
  input wire logic [DW-1:0] st_data_i,
  // Words toward storage
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [DW-1:0] out_data_o,
  // Observed state
  output logic [XW-1:0] acc_o,
  output logic [6:0] lzc_o,
  output logic [PW-1:0] xfer_o,
  output logic [GW-1:0] exp_o,
  output logic [RN*RW-1:0] residue_o
  );
  typedef struct packed {
    logic [5:0] shift;
    logic [BW-1:0] bmask;
    logic [3:0] sel;
    logic [3:0] allow;
    logic [4:0] emask;
    logic [4:0] fsh;
    logic [5:0] fmk;
    logic [XW-1:0] a;
    logic [XW-1:0] c;
    logic [XW-1:0] d;
    logic [DW-1:0] e;
    logic [XW-1:0] f;
    logic [DW-1:0] q;
    logic [PW-1:0] p;
    logic [5:0] rm;
    logic [1:0] qest;
    logic [3:0] ddig;
    logic [1:0] camt;
    logic [6:0] lzc;
    logic [GW-1:0] g;
    logic [GW-1:0] h;
    logic [RN*RW-1:0] res;
  } dp_s;
  dp_s state_reg;
  dp_s state_next;
  logic [DW-1:0] mmask;
  logic exec;
  logic push_op;
  logic push_rdy;
  logic [DW-1:0] push_data;

  // Residue modulo three over two-bit digits
  function automatic logic [RW-1:0] res3(input logic [XW-1:0] v);
    int s;
    s = 0;
    for (int i = 0; i < XW / 2; i++)
      s = s + int'(v[2*i+:2]);
    return RW'(s % 3);
  endfunction

  function automatic logic [DW-1:0] rotr(input logic [DW-1:0] v, input logic [5:0] s);
    logic [2*DW-1:0] t;
    t = {v, v} >> s;
    return t[DW-1:0];
  endfunction

  function automatic logic [DW-1:0] rotl(input logic [DW-1:0] v, input logic [5:0] s);
    logic [2*DW-1:0] t;
    t = {v, v} << s;
    return t[2*DW-1:DW];
  endfunction

  function automatic logic [BW-1:0] rot16(input logic [BW-1:0] v, input logic [3:0] s,
                                         input logic left);
    logic [2*BW-1:0] t;
    t = left ? ({v, v} << s) : ({v, v} >> s);
    return left ? t[2*BW-1:BW] : t[BW-1:0];
  endfunction

  // Run of low ones; a count of zero means the whole word
  function automatic logic [DW-1:0] lowmask(input logic [5:0] n);
    logic [DW:0] t;
    t = ({{DW{1'b0}}, 1'b1} << n) - 1'b1;
    return (n == '0) ? '1 : t[DW-1:0];
  endfunction

  // Decimal add digit by digit, returning the sum and the correction used
  function automatic logic [2*XW-1:0] bcd_add(input logic [XW-1:0] x, input logic [XW-1:0] y);
    logic [4:0] dg;
    logic cy;
    logic [XW-1:0] sm;
    logic [XW-1:0] cr;
    cy = 1'b0;
    sm = '0;
    cr = '0;
    for (int i = 0; i < XW / 4; i++)
    begin
      dg = {1'b0, x[4*i+:4]} + {1'b0, y[4*i+:4]} + {4'h0, cy};
      cy = dg > {1'b0, DEC_MAX};
      if (cy)
      begin
        dg = dg + {1'b0, DEC_ADJ};
        cr[4*i+:4] = DEC_ADJ;
      end
      sm[4*i+:4] = dg[3:0];
    end
    return {sm, cr};
  endfunction

  // Count of leading zeros in the 64-bit accumulator field
  function automatic logic [6:0] lz(input logic [DW-1:0] v);
    logic [6:0] n;
    logic hit;
    n = 7'h40;
    hit = 1'b0;
    for (int i = DW - 1; i >= 0; i--)
    begin
      if (v[i] && !hit)
      begin
        n = 7'(DW - 1 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // Binary multiply decoder over a six-bit multiplier window
  function automatic logic [1:0] mul_pick(input logic [5:0] w);
    logic [1:0] pair;
    pair = w[1:0];
    return pair;
  endfunction

  // Main mask built portion by portion
  // pattern per portion
  for (genvar k = 0; k < DW / BW; k++)
  begin : g_portion
    assign mmask[BW*k+:BW] = state_reg.allow[k] ? {BW{1'b1}} :
                             (state_reg.sel[k] ? state_reg.bmask : {BW{1'b0}});
  end

  // Commands that feed the FIFO stall while it is full
  always_comb
  begin
    case (op_e'(cmd_op_i))
      OP_INSERT, OP_FPUT, OP_G_INS, OP_STORE_A, OP_STORE_P: push_op = 1'b1;
      default: push_op = 1'b0;
    endcase
  end
  assign cmd_ready_o = !push_op || push_rdy;
  assign exec = cmd_valid_i && cmd_ready_o;

  // Next-state datapath
  always_comb
  begin
    logic [XW-1:0] sum;
    logic [XW-1:0] mult;
    logic [XW:0] rsh;
    logic [XW:0] t;
    logic [1:0] qd;
    logic [DW-1:0] lm;
    logic [BW-1:0] em;
    logic [BW-1:0] ex;
    logic [XW-1:0] e2;
    logic [XW-1:0] ex1;
    logic [2*XW-1:0] bs;
    logic [1:0] pk;
    sum = '0;
    mult = '0;
    rsh = '0;
    t = '0;
    qd = '0;
    lm = '0;
    em = BW'(({{BW{1'b0}}, 1'b1} << state_reg.emask) - 1'b1);
    ex = '0;
    ex1 = {{EW{1'b0}}, state_reg.e};
    e2 = ex1 << 1;
    bs = '0;
    pk = '0;
    push_data = '0;
    state_next = state_reg;
    if (exec)
    begin
      case (op_e'(cmd_op_i))
        OP_SHIFT: state_next.shift = st_data_i[SHF_LSB+:6];
        OP_MASK:
        begin
          state_next.bmask = st_data_i[MSK_BIT_LSB+:BW];
          state_next.sel = st_data_i[MSK_SEL_LSB+:4];
          state_next.allow = st_data_i[MSK_ALW_LSB+:4];
          state_next.emask = st_data_i[MSK_EXP_LSB+:5];
        end
        OP_FSAVE:
        begin
          state_next.fsh = st_data_i[FLT_SH_LSB+:5];
          state_next.fmk = st_data_i[FLT_MK_LSB+:6];
        end
        OP_EXTRACT: state_next.a = {{EW{1'b0}}, rotr(st_data_i, state_reg.shift) & mmask};
        OP_INSERT: push_data = rotl(state_reg.a[DW-1:0] & mmask, state_reg.shift) |
                               (st_data_i & ~rotl(mmask, state_reg.shift));
        OP_FPUT:
        begin
          lm = lowmask(state_reg.fmk);
          push_data = rotl(state_reg.a[DW-1:0] & lm, {1'b0, state_reg.fsh}) |
                      (st_data_i & ~rotl(lm, {1'b0, state_reg.fsh}));
        end
        OP_NORM: state_next.a[DW-1:0] = state_reg.a[DW-1:0] << state_reg.lzc;
        OP_SHR: state_next.a[DW-1:0] = state_reg.a[DW-1:0] >> state_reg.shift;
        OP_ADD:
        begin
          if (cmd_dec_i)
          begin
            bs = bcd_add(state_reg.a, state_reg.c);
            sum = bs[2*XW-1:XW];
            state_next.d = bs[XW-1:0];
          end
          else
            sum = state_reg.a + state_reg.c + state_reg.d;
          state_next.a = sum;
          if (cmd_fbuf_i)
            state_next.f = sum;
        end
        OP_LD_A: state_next.a = {{EW{1'b0}}, st_data_i};
        OP_LD_C: state_next.c = {{EW{1'b0}}, st_data_i};
        OP_LD_D: state_next.d = {{EW{1'b0}}, st_data_i};
        OP_LD_E:
        begin
          state_next.e = st_data_i;
          state_next.f = cmd_dec_i ? ({{EW{1'b0}}, st_data_i} << 1) :
                         ({{EW{1'b0}}, st_data_i} + ({{EW{1'b0}}, st_data_i} << 1));
        end
        OP_LD_Q:
        begin
          state_next.q = st_data_i;
          state_next.p = '0;
          state_next.ddig = st_data_i[3:0];
          pk = mul_pick(st_data_i[5:0]);
          state_next.c = (pk == 2'd1) ? ex1 : ((pk == 2'd2) ? e2 : '0);
          state_next.d = (pk == 2'd3) ? state_reg.f : '0;
          if (cmd_dec_i)
          begin
            state_next.camt = (st_data_i[3:0] >= 4'h2) ? 2'd2 : 2'(st_data_i[3:0]);
            state_next.c = (st_data_i[3:0] >= 4'h2) ? state_reg.f :
                           ((st_data_i[3:0] == 4'h1) ? ex1 : '0);
            state_next.d = '0;
          end
        end
        OP_MUL:
        begin
          if (!cmd_dec_i)
          begin
            sum = state_reg.a + state_reg.c + state_reg.d;
            state_next.a = sum >> 2;
            state_next.p = {state_reg.p[3:0], sum[1:0]};
            state_next.q = state_reg.q >> 2;
            pk = mul_pick(state_reg.q[7:2]);
            state_next.c = (pk == 2'd1) ? ex1 : ((pk == 2'd2) ? e2 : '0);
            state_next.d = (pk == 2'd3) ? state_reg.f : '0;
          end
          else
          begin
            if (state_reg.ddig != '0)
            begin
              bs = bcd_add(state_reg.a, state_reg.c);
              state_next.a = bs[2*XW-1:XW];
              state_next.d = bs[XW-1:0];
              state_next.ddig = state_reg.ddig - {2'b00, state_reg.camt};
            end
            else
            begin
              // finished digit out to transfer register
              state_next.a = state_reg.a >> 4;
              state_next.p = {state_reg.p[1:0], state_reg.a[3:0]};
              state_next.q = state_reg.q >> 4;
              state_next.ddig = state_reg.q[7:4];
            end
            state_next.camt = (state_next.ddig >= 4'h2) ? 2'd2 : 2'(state_next.ddig);
            state_next.c = (state_next.ddig >= 4'h2) ? state_reg.f :
                           ((state_next.ddig == 4'h1) ? ex1 : '0);
          end
        end
        // verify or correct the estimated pair
        OP_DIV:
        begin
          rsh = {1'b0, state_reg.a[XW-3:0], state_reg.q[DW-1:DW-2]};
          mult = (state_reg.qest == 2'd3) ? state_reg.f :
                 ((state_reg.qest == 2'd2) ? e2 : ((state_reg.qest == 2'd1) ? ex1 : '0));
          t = rsh - {1'b0, mult};
          qd = state_reg.qest;
          if (t[XW])
          begin
            t = t + {1'b0, ex1};
            qd = qd - 1'b1;
          end
          else if (t >= {1'b0, ex1} && qd != 2'd3)
          begin
            t = t - {1'b0, ex1};
            qd = qd + 1'b1;
          end
          state_next.a = t[XW-1:0];
          state_next.q = {state_reg.q[DW-3:0], qd};
          state_next.p = {state_reg.p[3:0], qd};
        end
        OP_G_EXT:
        begin
          ex = rot16(st_data_i[BW-1:0], state_reg.shift[3:0], 1'b0) & em;
          state_next.g = ex[GW-1:0];
        end
        OP_H_EXT:
        begin
          ex = rot16(st_data_i[BW-1:0], state_reg.shift[3:0], 1'b0) & em;
          state_next.h = ex[GW-1:0];
        end
        OP_EXP_ADD: state_next.g = state_reg.g + state_reg.h;
        OP_G_INS:
        begin
          ex = {{(BW-GW){1'b0}}, state_reg.g} & em;
          push_data = {st_data_i[DW-1:BW], rot16(ex, state_reg.shift[3:0], 1'b1) |
                       (st_data_i[BW-1:0] & ~rot16(em, state_reg.shift[3:0], 1'b1))};
        end
        OP_STORE_A: push_data = state_reg.a[DW-1:0];
        OP_STORE_P: push_data = {{(DW-PW){1'b0}}, state_reg.p};
        default: state_next = state_reg;
      endcase
    end
    state_next.rm = state_next.a[XW-3:XW-8];
    state_next.qest = (state_next.rm >= state_next.f[XW-1:XW-6]) ? 2'd3 :
                      (state_next.rm >= e2[XW-1:XW-6]) ? 2'd2 :
                      (state_next.rm >= ex1[XW-1:XW-6]) ? 2'd1 : 2'd0;
    state_next.lzc = lz(state_next.a[DW-1:0]);
    // residues track loads in the same cycle
    state_next.res[RI_SHIFT*RW+:RW] = res3(XW'(state_next.shift));
    state_next.res[RI_MASK*RW+:RW] = res3(XW'({state_next.allow, state_next.sel,
                                               state_next.bmask}));
    state_next.res[RI_FSH*RW+:RW] = res3(XW'(state_next.fsh));
    state_next.res[RI_FMK*RW+:RW] = res3(XW'(state_next.fmk));
    state_next.res[RI_A*RW+:RW] = res3(state_next.a);
    state_next.res[RI_CD*RW+:RW] = res3(state_next.c + state_next.d);
    state_next.res[RI_E*RW+:RW] = res3(XW'(state_next.e));
    state_next.res[RI_F*RW+:RW] = res3(state_next.f);
    state_next.res[RI_P*RW+:RW] = res3(XW'(state_next.p));
    state_next.res[RI_G*RW+:RW] = res3(XW'(state_next.g));
    state_next.res[RI_H*RW+:RW] = res3(XW'(state_next.h));
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Outbound FIFO toward storage
  arith_fifo #(.W(DW), .D(DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(exec && push_op),
    .in_ready_o(push_rdy),
    .in_data_i(push_data),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );

  // Observed state, all from registers
  assign acc_o = state_reg.a;
  assign lzc_o = state_reg.lzc;
  assign xfer_o = state_reg.p;
  assign exp_o = state_reg.g;
  assign residue_o = state_reg.res;
endmodule
`default_nettype wire

// File: arith_datapath_chk.sv
// Port-level checker for the arithmetic datapath top.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module arith_datapath_chk
  import arith_pkg::*;
  #(parameter int DEPTH = FIFO_DEPTH)
  (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Command side
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_op_i,
  input wire logic cmd_dec_i,
  input wire logic cmd_fbuf_i,
  input wire logic cmd_ready_o,
  input wire logic [DW-1:0] st_data_i,
  // Outbound words and state
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [DW-1:0] out_data_o,
  input wire logic [XW-1:0] acc_o,
  input wire logic [6:0] lzc_o,
  input wire logic [PW-1:0] xfer_o,
  input wire logic [GW-1:0] exp_o,
  input wire logic [RN*RW-1:0] residue_o
  );
  logic take_w;
  logic [DW-1:0] acc_lo_w;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Accepted command and low accumulator word
  assign take_w = cmd_valid_i && cmd_ready_o;
  assign acc_lo_w = acc_o[DW-1:0];
  property p_load; take_w && cmd_op_i == OP_LD_A |=> acc_lo_w == $past(st_data_i); endproperty
  a_load: assert property (p_load) else $error("accumulator load wrong");
  property p_lzc; acc_lo_w != '0 |-> (acc_lo_w >> (7'd63 - lzc_o)) == 64'h1; endproperty
  a_lzc: assert property (p_lzc) else $error("leading zero count wrong");
  property p_res_a; residue_o[RI_A*RW +: RW] == RW'(acc_o % 3); endproperty
  a_res_a: assert property (p_res_a) else $error("accumulator residue stale");
  property p_res_g; residue_o[RI_G*RW +: RW] == RW'(exp_o % 3); endproperty
  a_res_g: assert property (p_res_g) else $error("exponent residue stale");
  property p_refuse; !cmd_ready_o |-> out_valid_o; endproperty
  a_refuse: assert property (p_refuse) else $error("refused while empty");
  property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o); endproperty
  a_hold: assert property (p_hold) else $error("head word lost");
  property p_store;
    take_w && cmd_op_i == OP_STORE_A && !out_valid_o |=> out_valid_o && out_data_o == $past(acc_lo_w);
  endproperty
  a_store: assert property (p_store) else $error("stored word wrong");
  property p_stall; cmd_valid_i && !cmd_ready_o |=> $stable(acc_o); endproperty
  a_stall: assert property (p_stall) else $error("refused command acted");
endmodule
bind arith_datapath arith_datapath_chk #(.DEPTH(DEPTH)) chk_i (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_dec_i(cmd_dec_i),
  .cmd_fbuf_i(cmd_fbuf_i), .cmd_ready_o(cmd_ready_o), .st_data_i(st_data_i),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
  .acc_o(acc_o), .lzc_o(lzc_o), .xfer_o(xfer_o), .exp_o(exp_o), .residue_o(residue_o));
`default_nettype wire

// File: storage_model.sv
// Storage-side model: drains outbound words and stalls on request.
// Assumes the bench drives stall_i away from the rising edge.
`timescale 1ns/10ps
`default_nettype none
module storage_model
  import arith_pkg::*;
  (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Outbound word stream
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [DW-1:0] data_i,
  output logic ready_o
  );
  logic [DW-1:0] got[$];
  // Accept only while out of reset and not stalled
  assign ready_o = rst_n_i && !stall_i;
  // Record each word taken
  always @(posedge core_clk_i)
  begin
    if (valid_i && ready_o)
    begin
      got.push_back(data_i);
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the arithmetic datapath with a storage model.
// Assumes the design package and an 8-word outbound FIFO.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import arith_pkg::*;
  ;
  logic core_clk_i, rst_n_i, cmd_valid_i, cmd_dec_i, cmd_fbuf_i, cmd_ready_o;
  logic out_valid_o, out_ready_i, stall;
  logic [4:0] cmd_op_i;
  logic [DW-1:0] st_data_i, out_data_o, m;
  logic [XW-1:0] acc_o;
  logic [6:0] lzc_o;
  logic [PW-1:0] xfer_o;
  logic [GW-1:0] exp_o;
  logic [RN*RW-1:0] residue_o;
  int fail_count, n_checks, cyc;
  arith_datapath #(.DEPTH(FIFO_DEPTH)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_dec_i(cmd_dec_i),
    .cmd_fbuf_i(cmd_fbuf_i), .cmd_ready_o(cmd_ready_o), .st_data_i(st_data_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
    .acc_o(acc_o), .lzc_o(lzc_o), .xfer_o(xfer_o), .exp_o(exp_o), .residue_o(residue_o));
  storage_model SM (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .valid_i(out_valid_o), .data_i(out_data_o), .ready_o(out_ready_i));
  // Clock and hang limit
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      test_done();
    end
  end
  // Compare and count
  task automatic chk(input logic [XW-1:0] got, input logic [XW-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command, held until taken
  task automatic cmd(input logic [4:0] op, input logic [DW-1:0] d, input logic dec);
    int n;
    logic ok;
    n = 0;
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    st_data_i = d;
    cmd_dec_i = dec;
    // Ready is looked at between edges, where it has settled
    do
    begin
      #1;
      ok = cmd_ready_o;
      @(negedge core_clk_i);
      n++;
    end
    while (!ok && n < 50);
    if (!ok) chk(ok, 1'b1);
  endtask
  task automatic idle(input int n);
    cmd_valid_i = 1'b0;
    repeat (n) @(negedge core_clk_i);
  endtask
  // Expected mask and rotation
  function automatic logic [DW-1:0] mk(input logic [15:0] b, input logic [3:0] s, input logic [3:0] a);
    for (int k = 0; k < 4; k++)
    begin
      mk[16*k +: 16] = a[k] ? 16'hffff : (s[k] ? b : 16'h0000);
    end
  endfunction
  function automatic logic [DW-1:0] rr(input logic [DW-1:0] x, input logic [6:0] s);
    rr = (x >> s) | (x << (7'd64 - s));
  endfunction
  task automatic t_load;
    logic [DW-1:0] v[4] = '{64'h1, 64'h8000_0000_0000_0000, 64'h00ff_0000_0000_0000, 64'h0};
    logic [6:0] z[4] = '{7'd63, 7'd0, 7'd8, 7'd64};
    for (int i = 0; i < 4; i++)
    begin
      cmd(OP_LD_A, v[i], 1'b0);
      chk(acc_o, v[i]);
      chk(lzc_o, z[i]);
      chk(residue_o[RI_A*RW +: RW], v[i] % 3);
    end
    idle(1);
    $display("test load done");
  endtask
  task automatic t_barrel;
    m = mk(16'h0ff0, 4'b0100, 4'b0001);
    cmd(OP_SHIFT, 64'd12, 1'b0);
    cmd(OP_MASK, 64'h0814_0ff0, 1'b0);
    cmd(OP_EXTRACT, 64'h0123_4567_89ab_cdef, 1'b0);
    chk(acc_o, rr(64'h0123_4567_89ab_cdef, 7'd12) & m);
    cmd(OP_INSERT, 64'hffff_0000_ffff_0000, 1'b0);
    idle(3);
    chk(SM.got.size(), 1);
    chk(SM.got.pop_front(), rr(acc_o[DW-1:0] & m, 7'd52) | (64'hffff_0000_ffff_0000 & ~rr(m, 7'd52)));
    cmd(OP_G_EXT, 64'h1234, 1'b0);
    chk(exp_o, 12'h041);
    cmd(OP_LD_A, 64'hf000_0000_0000_0000, 1'b0);
    cmd(OP_SHR, 64'h0, 1'b0);
    chk(acc_o, 64'h000f_0000_0000_0000);
    cmd(OP_NORM, 64'h0, 1'b0);
    chk(acc_o, 64'hf000_0000_0000_0000);
    idle(1);
    $display("test barrel done");
  endtask
  task automatic t_add;
    cmd(OP_LD_A, 64'hffff_ffff_ffff_ffff, 1'b0);
    cmd(OP_LD_C, 64'h1, 1'b0);
    cmd(OP_LD_D, 64'h2, 1'b0);
    cmd(OP_ADD, 64'h0, 1'b0);
    chk(acc_o, 68'h1_0000_0000_0000_0002);
    cmd(OP_LD_A, 64'h19, 1'b0);
    cmd(OP_LD_C, 64'h08, 1'b0);
    cmd(OP_ADD, 64'h0, 1'b1);
    chk(acc_o, 68'h27);
    idle(1);
    $display("test add done");
  endtask
  task automatic t_fifo;
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      cmd(OP_LD_A, 64'd100 + i, 1'b0);
      cmd(OP_STORE_A, 64'h0, 1'b0);
    end
    @(negedge core_clk_i);
    chk(cmd_ready_o, 1'b0);
    chk(acc_o, 64'd107);
    stall = 1'b0;
    cmd(OP_STORE_A, 64'h0, 1'b0);
    idle(12);
    chk(SM.got.size(), 9);
    for (int i = 0; i < 9; i++) chk(SM.got[i], 64'd100 + (i < 8 ? i : 7));
    $display("test fifo done");
  endtask
  // Two binary multiply steps of 3 by 6, then exponent sum and insert
  task automatic t_mul_exp;
    cmd(OP_LD_A, 64'h0, 1'b0);
    cmd(OP_LD_E, 64'h3, 1'b0);
    cmd(OP_LD_Q, 64'h6, 1'b0);
    cmd(OP_MUL, 64'h0, 1'b0);
    cmd(OP_MUL, 64'h0, 1'b0);
    chk(acc_o, 68'h1);
    chk(xfer_o, 6'h08);
    chk(residue_o[RI_P*RW +: RW], 2'd2);
    cmd(OP_STORE_P, 64'h0, 1'b0);
    cmd(OP_H_EXT, 64'h1234, 1'b0);
    cmd(OP_EXP_ADD, 64'h0, 1'b0);
    chk(exp_o, 12'h082);
    cmd(OP_G_INS, 64'h0, 1'b0);
    idle(4);
    chk(SM.got.size(), 11);
    chk(SM.got[9], 64'h8);
    chk(SM.got[10], 64'h2008);
    $display("test mul exp done");
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst_n_i, cmd_valid_i, cmd_dec_i, cmd_fbuf_i, stall, cmd_op_i, st_data_i} = '0;
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk(acc_o, 0);
    chk(cmd_ready_o, 1'b1);
    t_load();
    t_barrel();
    t_add();
    t_fifo();
    t_mul_exp();
    test_done();
  end
endmodule
`default_nettype wire
